// >>> verilog/qdt_pkg.sv
// Shared constants and types for the quad converter trim register link
package qdt_pkg;
    // Write word layout: select[21:19], channel address[18:16], data[15:0]
    localparam int QDT_WORD_W = 22;
    localparam int QDT_SEL_LSB = 19;
    localparam int QDT_ADDR_LSB = 16;
    localparam int QDT_DATA_W = 16;
    localparam int QDT_NCH = 4;

    // Target select codes
    localparam logic [2:0] QDT_SEL_FUNC = 3'h0;
    localparam logic [2:0] QDT_SEL_DATA = 3'h2;
    localparam logic [2:0] QDT_SEL_SPAN = 3'h3;
    localparam logic [2:0] QDT_SEL_GAIN = 3'h4;
    localparam logic [2:0] QDT_SEL_OFFS = 3'h5;

    // Channel address codes; function-register address codes
    localparam logic [2:0] QDT_ADDR_ALL = 3'h4;
    localparam logic [2:0] QDT_FN_LOAD = 3'h5;

    // Field widths and reset values
    localparam int QDT_SPAN_W = 2;
    localparam int QDT_GAIN_W = 6;
    localparam int QDT_OFFS_W = 8;
    localparam logic [15:0] QDT_CODE_RST = 16'h0000;
    localparam logic [1:0] QDT_SPAN_RST = 2'h0;
    localparam logic [5:0] QDT_GAIN_RST = 6'h00;
    localparam logic [7:0] QDT_OFFS_RST = 8'h00;

    // Span codes
    localparam logic [1:0] QDT_SPAN_4096 = 2'h0;
    localparam logic [1:0] QDT_SPAN_4201 = 2'h1;
    localparam logic [1:0] QDT_SPAN_4312 = 2'h2;

    // Host APB register map (byte offsets)
    localparam logic [7:0] QDT_REG_CMD = 8'h00;
    localparam logic [7:0] QDT_REG_STAT = 8'h04;
    localparam logic [7:0] QDT_REG_CLAMP = 8'h08;
    localparam int QDT_CMD_GO_BIT = 31;
    localparam int QDT_CLAMP_BIT = 0;
    localparam int QDT_STAT_BUSY_BIT = 0;
    localparam int QDT_STAT_DET_BIT = 1;

    typedef enum logic [1:0] {
        QDT_IDLE = 2'b00,
        QDT_SEND = 2'b01,
        QDT_WAIT = 2'b11
    } qdt_host_e;
endpackage

// >>> verilog/qdt_link_if.sv
// Word link between the host controller and the trim register device
interface qdt_link_if;
    logic [21:0] word;
    logic word_valid;
    logic ext_clamp_request_n;
    logic supply_detect_out_n;

    modport host (
        output word,
        output word_valid,
        output ext_clamp_request_n,
        input supply_detect_out_n
    );
    modport dev (
        input word,
        input word_valid,
        input ext_clamp_request_n,
        output supply_detect_out_n
    );
endinterface

// >>> verilog/qdt_dev.sv
// Device end: decodes write words into per-channel code and trim registers
//
// Chosen here: the APB interface to the registers and the placing of the registers.
module qdt_dev
    import qdt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link to host
    qdt_link_if.dev link,
    // Analog-side status and controls
    input wire logic supply_ok,
    output logic amp_connect_gate,
    output logic ground_clamp_gate,
    // Per-channel outputs to the converter cores
    output logic [QDT_NCH-1:0][15:0] active_code,
    output logic [QDT_NCH-1:0][1:0] span_code,
    output logic [QDT_NCH-1:0][5:0] gain_trim,
    output logic [QDT_NCH-1:0][7:0] offset_trim
);
    logic [QDT_NCH-1:0][15:0] pend_ff, nxt_pend;
    logic [QDT_NCH-1:0][15:0] code_ff, nxt_code;
    logic [QDT_NCH-1:0][1:0] span_ff, nxt_span;
    logic [QDT_NCH-1:0][5:0] gain_ff, nxt_gain;
    logic [QDT_NCH-1:0][7:0] offs_ff, nxt_offs;
    logic released_ff, nxt_released;
    logic [2:0] sel;
    logic [2:0] addr;
    logic [15:0] data;
    logic [QDT_NCH-1:0] hit;
    logic wr_code;
    logic wr_span;
    logic wr_gain;
    logic wr_offs;
    logic do_load;
    logic clamp_hold;

    function automatic logic [QDT_NCH-1:0] chan_hit(input logic [2:0] a);
        chan_hit = '0;
        if (a == QDT_ADDR_ALL) begin
            chan_hit = '1;
        end else if (a < 3'(QDT_NCH)) begin
            chan_hit[a[1:0]] = 1'b1;
        end
    endfunction

    // A word reaches a register group only if its select matches and some channel is hit
    function automatic logic sel_write(input logic valid, input logic [2:0] s,
        input logic [2:0] want, input logic [QDT_NCH-1:0] h);
        sel_write = valid && (s == want) && (|h);
    endfunction

    // Word fields: select, channel address, data
    assign sel = link.word[QDT_SEL_LSB +: 3];
    assign addr = link.word[QDT_ADDR_LSB +: 3];
    assign data = link.word[QDT_DATA_W-1:0];

    // Decoded once and shared, so every group sees the same channel mask
    assign hit = chan_hit(addr);
    assign wr_code = sel_write(link.word_valid, sel, QDT_SEL_DATA, hit);
    assign wr_span = sel_write(link.word_valid, sel, QDT_SEL_SPAN, hit);
    assign wr_gain = sel_write(link.word_valid, sel, QDT_SEL_GAIN, hit);
    assign wr_offs = sel_write(link.word_valid, sel, QDT_SEL_OFFS, hit);
    assign do_load = link.word_valid && (sel == QDT_SEL_FUNC) && (addr == QDT_FN_LOAD);

    // Pending codes wait here so one load moves all channels together
    // all sixteen bits form code
    always_comb begin
        nxt_pend = pend_ff;
        for (int i = 0; i < QDT_NCH; i++) begin
            if (wr_code && hit[i]) begin
                nxt_pend[i] = data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pend_ff <= {QDT_NCH{QDT_CODE_RST}};
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // Trims apply at once; only the codes are double buffered
    // load copies every pending code
    always_comb begin
        nxt_code = code_ff;
        if (do_load) begin
            nxt_code = pend_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            code_ff <= {QDT_NCH{QDT_CODE_RST}};
        end else begin
            code_ff <= nxt_code;
        end
    end

    // two low bits, stored as written
    always_comb begin
        nxt_span = span_ff;
        for (int i = 0; i < QDT_NCH; i++) begin
            if (wr_span && hit[i]) begin
                nxt_span[i] = data[QDT_SPAN_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            span_ff <= {QDT_NCH{QDT_SPAN_RST}};
        end else begin
            span_ff <= nxt_span;
        end
    end

    always_comb begin
        nxt_gain = gain_ff;
        for (int i = 0; i < QDT_NCH; i++) begin
            if (wr_gain && hit[i]) begin
                nxt_gain[i] = data[QDT_GAIN_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gain_ff <= {QDT_NCH{QDT_GAIN_RST}};
        end else begin
            gain_ff <= nxt_gain;
        end
    end

    always_comb begin
        nxt_offs = offs_ff;
        for (int i = 0; i < QDT_NCH; i++) begin
            if (wr_offs && hit[i]) begin
                nxt_offs[i] = data[QDT_OFFS_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            offs_ff <= {QDT_NCH{QDT_OFFS_RST}};
        end else begin
            offs_ff <= nxt_offs;
        end
    end

    assign clamp_hold = !supply_ok || !link.ext_clamp_request_n;

    // only a channel data word releases
    always_comb begin
        nxt_released = released_ff;
        if (clamp_hold) begin
            nxt_released = 1'b0;
        end else if (wr_code) begin
            nxt_released = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            released_ff <= 1'b0;
        end else begin
            released_ff <= nxt_released;
        end
    end

    // release connects amplifier and opens ground path
    assign amp_connect_gate = released_ff;
    assign ground_clamp_gate = ~released_ff;
    assign link.supply_detect_out_n = ~supply_ok;

    // span, gain and offset trims are applied in the analog core
    assign active_code = code_ff;
    assign span_code = span_ff;
    assign gain_trim = gain_ff;
    assign offset_trim = offs_ff;
endmodule

// >>> verilog/qdt_host.sv
// Host end: APB registers that send write words over the link
module qdt_host
    import qdt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to device
    qdt_link_if.host link
);
    qdt_host_e st_ff, nxt_st;
    logic [21:0] word_ff, nxt_word;
    logic clamp_ff, nxt_clamp;
    logic [31:0] rd_ff, nxt_rd;
    logic wr, rd;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always_comb begin
        nxt_st = st_ff;
        nxt_word = word_ff;
        nxt_clamp = clamp_ff;
        nxt_rd = rd_ff;
        unique case (st_ff)
            QDT_IDLE: begin
                if (wr && paddr == QDT_REG_CMD && pwdata[QDT_CMD_GO_BIT]) begin
                    nxt_word = pwdata[QDT_WORD_W-1:0];
                    nxt_st = QDT_SEND;
                end
            end
            QDT_SEND: nxt_st = QDT_WAIT;
            QDT_WAIT: nxt_st = QDT_IDLE;
            default: nxt_st = QDT_IDLE;
        endcase
        if (wr && paddr == QDT_REG_CLAMP) begin
            nxt_clamp = pwdata[QDT_CLAMP_BIT];
        end
        if (rd) begin
            nxt_rd = '0;
            unique case (paddr)
                QDT_REG_CMD: nxt_rd[QDT_WORD_W-1:0] = word_ff;
                QDT_REG_STAT: begin
                    nxt_rd[QDT_STAT_BUSY_BIT] = (st_ff != QDT_IDLE);
                    nxt_rd[QDT_STAT_DET_BIT] = ~link.supply_detect_out_n;
                end
                QDT_REG_CLAMP: nxt_rd[QDT_CLAMP_BIT] = clamp_ff;
                default: nxt_rd = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_ff <= QDT_IDLE;
            word_ff <= '0;
            clamp_ff <= 1'b0;
            rd_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            word_ff <= nxt_word;
            clamp_ff <= nxt_clamp;
            rd_ff <= nxt_rd;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr != QDT_REG_CMD) && (paddr != QDT_REG_STAT)
        && (paddr != QDT_REG_CLAMP);
    assign prdata = rd_ff;
    assign link.word = word_ff;
    assign link.word_valid = (st_ff == QDT_SEND);
    assign link.ext_clamp_request_n = ~clamp_ff;
endmodule

// >>> test/qdt_link_checker.sv
// Assertions on the host-device word link and the output clamp gates
module qdt_link_checker
    import qdt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link signals
    input wire logic [21:0] word,
    input wire logic word_valid,
    input wire logic ext_clamp_request_n,
    input wire logic supply_detect_out_n,
    // Device clamp side
    input wire logic supply_ok,
    input wire logic amp_connect_gate,
    input wire logic ground_clamp_gate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic rel_ok;
    // Only a data write to a real channel may release the clamp
    assign rel_ok = word_valid && word[21:19] == QDT_SEL_DATA && word[18:16] <= QDT_ADDR_ALL
        && supply_ok && ext_clamp_request_n;
    pulse_gap_a: assert property (word_valid |=> !word_valid [*2])
        else $error("word pulses too close");
    word_hold_a: assert property ($changed(word) |-> word_valid)
        else $error("word changed without pulse");
    gates_excl_a: assert property (ground_clamp_gate == !amp_connect_gate)
        else $error("gates not exclusive");
    ext_clamp_a: assert property (!ext_clamp_request_n |=> !amp_connect_gate)
        else $error("amp connected under clamp request");
    supply_clamp_a: assert property (!supply_ok |=> !amp_connect_gate)
        else $error("amp connected on bad supply");
    detect_out_a: assert property (supply_detect_out_n == !supply_ok)
        else $error("detector output wrong");
    clamp_release_a: assert property (rel_ok |=> amp_connect_gate)
        else $error("clamp not released");
    rise_cause_a: assert property ($rose(amp_connect_gate) |-> $past(rel_ok))
        else $error("clamp released without data write");
endmodule

// >>> test/quad_dac_channel_trim_regs_tb.sv
// Bench: APB host end driving the trim register device end
module quad_dac_channel_trim_regs_tb
    import qdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic supply_ok = 1'b0, pready, pslverr, amp, gnd, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0][15:0] code;
    logic [3:0][1:0] span;
    logic [3:0][5:0] gain;
    logic [3:0][7:0] offs;
    int error_cnt = 0, n_tests = 0;
    qdt_link_if link ();
    qdt_host u_qdt_host (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.host));
    qdt_dev u_qdt_dev (.sys_clk(sys_clk), .nrst(nrst), .link(link.dev), .supply_ok(supply_ok),
        .amp_connect_gate(amp), .ground_clamp_gate(gnd), .active_code(code), .span_code(span),
        .gain_trim(gain), .offset_trim(offs));
    qdt_link_checker u_qdt_link_checker (.sys_clk(sys_clk), .nrst(nrst), .word(link.word),
        .word_valid(link.word_valid), .ext_clamp_request_n(link.ext_clamp_request_n),
        .supply_detect_out_n(link.supply_detect_out_n), .supply_ok(supply_ok),
        .amp_connect_gate(amp), .ground_clamp_gate(gnd));
    always #50 sys_clk = ~sys_clk;
    task automatic results();
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            chk(0, 1);
            results();
        end
    endtask
    // Wait for the host to finish the word before the next command
    task automatic send(input logic [2:0] s, input logic [2:0] a, input logic [15:0] d);
        int n;
        apb(1'b1, QDT_REG_CMD, {1'b1, 9'h000, s, a, d});
        for (n = 0; n < 16; n++) begin
            apb(1'b0, QDT_REG_STAT, 32'h0);
            if (rd[QDT_STAT_BUSY_BIT] === 1'b0) break;
        end
        if (n == 16) begin
            chk(rd, 0);
            results();
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        settle();
        chk({amp, gnd, link.ext_clamp_request_n}, 3'b011);
        chk({span, gain}, 0);
        chk(offs, 0);
        @(posedge sys_clk) supply_ok <= 1'b1;
        apb(1'b0, QDT_REG_STAT, 32'h0);
        chk(rd[QDT_STAT_DET_BIT], 1);
        send(QDT_SEL_DATA, QDT_ADDR_ALL, 16'ha5c3);
        chk(link.word, {QDT_SEL_DATA, QDT_ADDR_ALL, 16'ha5c3});
        chk(code[0], 0);
        chk(amp, 1);
        apb(1'b0, QDT_REG_CMD, 32'h0);
        chk(rd, {10'h000, QDT_SEL_DATA, QDT_ADDR_ALL, 16'ha5c3});
        send(QDT_SEL_FUNC, QDT_FN_LOAD, 16'h0000);
        for (int i = 0; i < 4; i++) chk(code[i], 16'ha5c3);
        // Gain and offset codes straddle the sign boundary
        for (int i = 0; i < 4; i++) begin
            send(QDT_SEL_DATA, i[2:0], 16'h1000 + 16'(i));
            send(QDT_SEL_SPAN, i[2:0], 16'hfffc | 16'(i % 3));
            send(QDT_SEL_GAIN, i[2:0], 16'hffc0 | 16'(6'h1f + i));
            send(QDT_SEL_OFFS, i[2:0], 16'hff00 | 16'(8'h7f + i));
        end
        send(QDT_SEL_FUNC, QDT_FN_LOAD, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            chk(code[i], 16'h1000 + i);
            chk(span[i], i % 3);
            chk(gain[i], 6'(6'h1f + i));
            chk(offs[i], 8'(8'h7f + i));
        end
        send(QDT_SEL_DATA, 3'h7, 16'hdead);
        send(3'h6, 3'h0, 16'hffff);
        send(QDT_SEL_FUNC, QDT_FN_LOAD, 16'h0000);
        chk(code[3], 16'h1003);
        chk(gain[0], 6'h1f);
        apb(1'b1, QDT_REG_CLAMP, 32'h1);
        settle();
        chk({amp, gnd, link.ext_clamp_request_n}, 3'b010);
        apb(1'b1, QDT_REG_CLAMP, 32'h0);
        settle();
        chk(amp, 0);
        send(QDT_SEL_DATA, 3'h0, 16'h0001);
        chk(amp, 1);
        @(posedge sys_clk) supply_ok <= 1'b0;
        settle();
        chk({amp, gnd, link.supply_detect_out_n}, 3'b011);
        apb(1'b0, 8'h0c, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        results();
    end
endmodule
